/* core/io_seq_pkg.sv */
// Constants, types and register map shared by the I/O sequencer files.
// Assumes a single 20 MHz clock domain and an APB register master.
package io_seq_pkg;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int DEV_TIMEOUT_NS  = 10000;
  // A longest wait rounds down to whole cycles.
  localparam int DEV_TIMEOUT_CYC = DEV_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DEV       = 8'h04;
  localparam logic [7:0] OFS_OPND      = 8'h08;
  localparam logic [7:0] OFS_OPND_NEXT = 8'h0C;
  localparam logic [7:0] OFS_PSW       = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;

  // Word bit 0 is the most significant, so word bit 7 is index 8.
  localparam int         PSW_PROT_BIT   = 8;
  localparam int         CC_W           = 4;
  localparam logic [3:0] CC_NONE        = 4'h0;
  localparam logic [3:0] CC_TIMEOUT     = 4'h4;
  localparam logic [3:0] CC_PROTECT     = 4'h8;
  localparam logic [15:0] RST_PSW       = 16'h0000;
  localparam logic [15:0] RST_HALF      = 16'h0000;

  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_BADOP_BIT   = 2;

  // Opcode bit 1 (index 6) selects the memory form of an instruction.
  localparam int         OPC_FORM_BIT = 6;
  localparam logic [7:0] OPC_CMD      = 8'h9E;
  localparam logic [7:0] OPC_RD       = 8'h9B;
  localparam logic [7:0] OPC_WR       = 8'h9A;
  localparam logic [7:0] OPC_RDH      = 8'h99;
  localparam logic [7:0] OPC_WRH      = 8'h98;
  localparam logic [7:0] OPC_BLKR     = 8'h97;
  localparam logic [7:0] OPC_BLKW     = 8'h96;
  localparam logic [7:0] OPC_LOAD     = 8'h95;

  localparam logic [15:0] LOAD_DEV_LOC = 16'h0078;
  localparam logic [15:0] LOAD_BASE    = 16'h0080;
  localparam logic [1:0]  LOAD_LAST    = 2'h1;
  localparam logic [1:0]  BLK_LAST     = 2'h3;

  typedef enum logic [2:0] {
    K_CMD, K_RD, K_WR, K_RDH, K_WRH, K_BLKR, K_BLKW, K_LOAD
  } op_kind_t;

  typedef enum logic [1:0] {
    DK_CMD = 2'h0, DK_WR = 2'h1, DK_RD = 2'h2
  } dev_kind_t;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_PREP    = 7'h02,
    ST_FETCH   = 7'h04,
    ST_DEV_REQ = 7'h08,
    ST_DEV_REL = 7'h10,
    ST_STORE   = 7'h20,
    ST_DONE    = 7'h40
  } seq_state_t;

  typedef struct packed {
    logic        req;
    dev_kind_t   kind;
    logic [15:0] addr;
    logic [7:0]  data;
  } dev_out_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_out_t;

endpackage

/* core/pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes the group is held stable while it is being sampled.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk, // System clock.
  input  wire logic         rst,     // Asynchronous reset.
  input  wire logic [W-1:0] din,     // Pin levels.
  output logic      [W-1:0] dout     // Synchronised levels.
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pin_sync

/* core/io_watchdog.sv */
// Cycle counter that bounds one device bus transaction.
// Assumes clear is high between transactions and on each new one.
`timescale 1ns/1ps
module io_watchdog #(
  parameter int CYC = 200
) (
  input  wire logic sys_clk, // System clock.
  input  wire logic rst,     // Asynchronous reset.
  input  wire logic clear,   // Restart the count.
  output logic      expired  // Limit reached, held until clear.
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYC);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_expired;

  always_comb begin
    next_cnt = cnt;
    next_expired = expired;
    if (clear) begin
      next_cnt = '0;
      next_expired = 1'b0;
    end else if (cnt != LIMIT) begin
      next_cnt = cnt + CW'(1);
      next_expired = (cnt + CW'(1)) == LIMIT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule // io_watchdog

/* core/io_instruction_sequencer.sv */
// Programmed I/O instruction sequencer: byte, pair, block and bootstrap
// transfers between processor memory and multiplexor bus devices.
// Assumes a same-clock memory port and devices that answer a four-phase
// request/acknowledge handshake.
// How it works
// [R1] Send command byte to addressed device.
// [R2] Device flags failed commands in status.
// [R3] Byte read fills low byte, clears high.
// [R4] Byte write sends low byte unchanged.
// [R5] Block limits from operand and next halfword.
// [R6] Software keeps start not above end.
// [R7] Block moves start through end inclusive.
// [R8] Block read stores ascending memory bytes.
// [R9] Block write sends ascending memory bytes.
// [R10] Nothing else runs during a block.
// [R11] Block cc zero if normal, else nonzero.
// [R12] Pair read: first byte high, second low.
// [R13] Pair write: high byte first, low next.
// [R14] Bootstrap device and command from 78, 79.
// [R15] Bootstrap stores upward from address 80.
// [R16] Bootstrap skips leading zero bytes only.
// [R17] Bootstrap stops after storing final address.
// [R18] Bootstrap instruction carries zero register field.
// [R19] Transfer stores obey memory protection.
// [R20] Protect mode traps, no transfer done.
// [R21] Device time-out abandons and sets V.
// [R22] Fixed counter bounds each device wait.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module io_instruction_sequencer
  import io_seq_pkg::*;
#(
  parameter int TIMEOUT_CYC = io_seq_pkg::DEV_TIMEOUT_CYC
) (
  input  wire logic                sys_clk,     // System clock.
  input  wire logic                rst,         // Asynchronous reset.
  input  wire logic [7:0]          paddr,       // APB address.
  input  wire logic                psel,        // APB select.
  input  wire logic                penable,     // APB enable.
  input  wire logic                pwrite,      // APB direction.
  input  wire logic [31:0]         pwdata,      // APB write data.
  output logic      [31:0]         prdata,      // APB read data.
  output logic                     pready,      // APB ready.
  output logic                     pslverr,     // APB error.
  output io_seq_pkg::dev_out_t     dev_o,       // Device bus request.
  input  wire logic                dev_ack,     // Device acknowledge pin.
  input  wire logic [7:0]          dev_rdata,   // Device data pins.
  output io_seq_pkg::mem_out_t     mem_o,       // Memory request.
  input  wire logic [7:0]          mem_rdata,   // Memory read byte.
  input  wire logic                mem_ack,     // Memory done.
  input  wire logic                mem_fault,   // Protected store refused.
  output logic                     illegal_irq, // Privilege trap pulse.
  output logic                     cpu_hold     // Instruction stream held.
);
  import io_seq_pkg::*;

  seq_state_t  state, next_state;
  op_kind_t    op, next_op, dkind;
  dev_out_t    next_dev;
  mem_out_t    next_mem;
  logic        memf, next_memf, idx, next_idx, leader, next_leader;
  logic        cmdph, next_cmdph, res_we, next_res_we, cc_we, next_cc_we;
  logic        next_illegal, badop, next_badop, next_hold;
  logic        txn_new, next_txn_new, dvalid, wd_exp, ack_s, start;
  logic        next_start, next_pready, next_pslverr, fin;
  logic        dir_in, srcmem, dstmem, at_end;
  logic [1:0]  pidx, next_pidx;
  logic [23:0] psh, next_psh;
  logic [31:0] full, next_prdata;
  logic [15:0] ptr, next_ptr, last, next_last, target, next_target;
  logic [15:0] res, next_res, devreg, next_devreg, opnd, next_opnd;
  logic [15:0] opnd_next, next_opnd_next, processor_state_word, next_psw, pbase;
  logic [7:0]  byte_r, next_byte, rdata_s, opcode, next_opcode, opc_base;
  logic [3:0]  cc_r, next_cc;
  logic [2:0]  sticky, next_sticky;
  seq_state_t  elem_st;

  pin_sync #(.W(9)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({dev_ack, dev_rdata}),
    .dout    ({ack_s, rdata_s})
  );

  io_watchdog #(.CYC(TIMEOUT_CYC)) u_wd (
    .sys_clk (sys_clk),
    .rst     (rst),
    // Clearing as a new wait is entered keeps a late expiry of the last
    // wait from cutting the next one short.
    .clear   (txn_new || next_txn_new ||
              !(state inside {ST_DEV_REQ, ST_DEV_REL})), // R22
    .expired (wd_exp)
  );

  assign fin = (state == ST_DONE);

  // Register file. Writes other than status clears are ignored while an
  // instruction runs, so operands cannot shift under a transfer.
  always_comb begin
    next_opcode = opcode;
    next_devreg = devreg;
    next_opnd = opnd;
    next_opnd_next = opnd_next;
    next_psw = processor_state_word;
    next_sticky = sticky;
    next_start = 1'b0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_pready = 1'b1;
      case (paddr)
        OFS_CTRL:      next_prdata = {24'h00_0000, opcode};
        OFS_DEV:       next_prdata = {16'h0000, devreg};
        OFS_OPND:      next_prdata = {16'h0000, opnd};
        OFS_OPND_NEXT: next_prdata = {16'h0000, opnd_next};
        OFS_PSW:       next_prdata = {16'h0000, processor_state_word};
        OFS_STATUS:    next_prdata = {29'h0000_0000, sticky[2:1], cpu_hold};
        default: begin
          next_prdata = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == OFS_STATUS) begin
        next_sticky = sticky & ~pwdata[2:0];
      end else if (!cpu_hold && !start) begin // R10
        case (paddr)
          OFS_CTRL: begin
            next_opcode = pwdata[7:0];
            next_start = 1'b1;
          end
          OFS_DEV:       next_devreg = pwdata[15:0];
          OFS_OPND:      next_opnd = pwdata[15:0];
          OFS_OPND_NEXT: next_opnd_next = pwdata[15:0];
          OFS_PSW:       next_psw = pwdata[15:0];
          default: ;
        endcase
      end
    end
    // Hardware events are applied last, so a set beats a same-cycle clear.
    if (illegal_irq) next_sticky[ST_ILLEGAL_BIT] = 1'b1;
    if (badop) next_sticky[ST_BADOP_BIT] = 1'b1;
    next_sticky[ST_BUSY_BIT] = 1'b0;
    if (fin && cc_we) next_psw[CC_W-1:0] = cc_r; // R11
    if (fin && res_we) next_opnd = res; // R3 R12
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opcode <= 8'h00;
      devreg <= RST_HALF;
      opnd <= RST_HALF;
      opnd_next <= RST_HALF;
      processor_state_word <= RST_PSW;
      sticky <= 3'h0;
      start <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      opcode <= next_opcode;
      devreg <= next_devreg;
      opnd <= next_opnd;
      opnd_next <= next_opnd_next;
      processor_state_word <= next_psw;
      sticky <= next_sticky;
      start <= next_start;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  assign opc_base = opcode & ~(8'h01 << OPC_FORM_BIT);
  assign dir_in = op inside {K_RD, K_RDH, K_BLKR, K_LOAD};
  assign srcmem = memf || (op == K_BLKW);
  assign dstmem = memf || (op == K_BLKR) || (op == K_LOAD);
  assign at_end = (ptr == last); // R7 R17
  assign elem_st = (!dir_in && srcmem) ? ST_FETCH : ST_DEV_REQ; // R9
  assign full = {psh, mem_rdata};

  always_comb begin
    dvalid = 1'b1;
    dkind = K_CMD;
    case (opc_base)
      OPC_CMD:  dkind = K_CMD;
      OPC_RD:   dkind = K_RD;
      OPC_WR:   dkind = K_WR;
      OPC_RDH:  dkind = K_RDH;
      OPC_WRH:  dkind = K_WRH;
      OPC_BLKR: dkind = K_BLKR;
      OPC_BLKW: dkind = K_BLKW;
      OPC_LOAD: dkind = K_LOAD;
      default:  dvalid = 1'b0;
    endcase
    // Bootstrap exists only in memory form.
    if (opc_base == OPC_LOAD) dvalid = opcode[OPC_FORM_BIT];
  end

  always_comb begin
    next_state = state;
    next_op = op;
    next_memf = memf;
    next_ptr = ptr;
    next_last = last;
    next_idx = idx;
    next_pidx = pidx;
    next_psh = psh;
    next_byte = byte_r;
    next_leader = leader;
    next_cmdph = cmdph;
    next_target = target;
    next_res = res;
    next_res_we = res_we;
    next_cc = cc_r;
    next_cc_we = cc_we;
    next_illegal = 1'b0;
    next_badop = 1'b0;
    unique case (state)
      ST_IDLE: if (start) begin
        next_res_we = 1'b0;
        next_cc_we = 1'b0;
        next_state = ST_DONE;
        if (!dvalid) begin
          next_badop = 1'b1;
        end else if (processor_state_word[PSW_PROT_BIT]) begin
          next_illegal = 1'b1; // R20
        end else begin
          next_op = dkind;
          next_memf = opcode[OPC_FORM_BIT];
          next_ptr = opnd; // R1 R4 R5
          next_last = (dkind inside {K_RDH, K_WRH}) ? opnd + 16'h0001 : opnd;
          next_idx = 1'b0;
          next_pidx = 2'h0;
          next_leader = 1'b1;
          next_cmdph = (dkind == K_LOAD);
          next_target = devreg;
          next_res = opnd;
          next_cc_we = 1'b1;
          next_cc = CC_NONE;
          if (dkind == K_LOAD || (dkind inside {K_BLKR, K_BLKW} &&
              opcode[OPC_FORM_BIT])) begin
            next_state = ST_PREP; // R5 R14
          end else begin
            if (dkind inside {K_BLKR, K_BLKW}) next_last = opnd_next; // R5
            next_state = (dkind == K_BLKW || (opcode[OPC_FORM_BIT] &&
              dkind inside {K_CMD, K_WR, K_WRH})) ? ST_FETCH : ST_DEV_REQ;
          end
        end
      end
      ST_PREP: if (mem_ack) begin
        next_psh = full[23:0];
        next_pidx = pidx + 2'h1;
        if (pidx == ((op == K_LOAD) ? LOAD_LAST : BLK_LAST)) begin
          if (op == K_LOAD) begin
            next_target = {8'h00, full[15:8]}; // R14
            next_byte = full[7:0];
            next_ptr = LOAD_BASE; // R15
            next_state = ST_DEV_REQ;
          end else begin
            next_ptr = full[31:16]; // R5
            next_last = full[15:0];
            next_state = (op == K_BLKW) ? ST_FETCH : ST_DEV_REQ;
          end
        end
      end
      ST_FETCH: if (mem_ack) begin
        next_byte = mem_rdata;
        next_state = ST_DEV_REQ;
      end
      ST_DEV_REQ: if (wd_exp) begin
        next_cc = CC_TIMEOUT; // R21
        next_state = ST_DONE;
      end else if (ack_s) begin
        if (dir_in && !cmdph) next_byte = rdata_s;
        next_state = ST_DEV_REL;
      end
      ST_DEV_REL: if (wd_exp) begin
        next_cc = CC_TIMEOUT; // R21
        next_state = ST_DONE;
      end else if (!ack_s) begin
        if (cmdph) begin
          next_cmdph = 1'b0;
          next_state = ST_DEV_REQ;
        end else if (op == K_LOAD && leader && byte_r == 8'h00) begin
          next_state = ST_DEV_REQ; // R16
        end else if (dir_in && dstmem) begin
          next_state = ST_STORE; // R8
        end else begin
          if (dir_in) begin
            next_res_we = 1'b1;
            next_res = (op == K_RDH) ? {res[7:0], byte_r} // R12
                                     : {8'h00, byte_r}; // R3
          end
          next_state = at_end ? ST_DONE : elem_st;
          next_ptr = at_end ? ptr : ptr + 16'h0001;
          next_idx = 1'b1;
        end
      end
      ST_STORE: if (mem_ack) begin
        if (mem_fault) begin
          next_cc = CC_PROTECT; // R19 R11
          next_state = ST_DONE;
        end else begin
          next_leader = 1'b0;
          next_state = at_end ? ST_DONE : elem_st; // R7 R10 R17
          next_ptr = at_end ? ptr : ptr + 16'h0001; // R8
          next_idx = 1'b1;
        end
      end
      ST_DONE: next_state = ST_IDLE;
    endcase
    next_hold = (next_state != ST_IDLE); // R10
    next_txn_new = (next_state == ST_DEV_REQ) && (state != ST_DEV_REQ);
    next_dev.req = (next_state == ST_DEV_REQ);
    next_dev.addr = next_target;
    if (next_cmdph || next_op == K_CMD) next_dev.kind = DK_CMD; // R1
    else if (next_op inside {K_RD, K_RDH, K_BLKR, K_LOAD}) next_dev.kind = DK_RD;
    else next_dev.kind = DK_WR;
    if (next_memf || next_op inside {K_BLKW, K_LOAD}) next_dev.data = next_byte;
    else if (next_op == K_WRH && !next_idx) next_dev.data = opnd[15:8]; // R13
    else next_dev.data = opnd[7:0]; // R1 R4
    pbase = (next_op == K_LOAD) ? LOAD_DEV_LOC : next_ptr;
    next_mem.req = next_state inside {ST_PREP, ST_FETCH, ST_STORE};
    next_mem.we = (next_state == ST_STORE);
    next_mem.addr = (next_state == ST_PREP) ? pbase + {14'h0000, next_pidx}
                                            : next_ptr;
    next_mem.wdata = next_byte;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      op <= K_CMD;
      {memf, idx, leader, cmdph, res_we, cc_we} <= 6'h00;
      {illegal_irq, badop, cpu_hold, txn_new} <= 4'h0;
      {ptr, last, target, res} <= 64'h0000_0000_0000_0000;
      {pidx, byte_r, cc_r} <= 14'h0000;
      psh <= 24'h00_0000;
      dev_o <= '0;
      mem_o <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      {memf, idx, leader} <= {next_memf, next_idx, next_leader};
      {cmdph, res_we, cc_we} <= {next_cmdph, next_res_we, next_cc_we};
      {illegal_irq, badop} <= {next_illegal, next_badop};
      {cpu_hold, txn_new} <= {next_hold, next_txn_new};
      {ptr, last, target, res} <= {next_ptr, next_last, next_target, next_res};
      {pidx, byte_r, cc_r} <= {next_pidx, next_byte, next_cc};
      psh <= next_psh;
      dev_o <= next_dev;
      mem_o <= next_mem;
    end
  end

  localparam int WAIT_BOUND = 260;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence trap_seq;
    illegal_irq && !dev_o.req && !mem_o.req ##1 !cpu_hold;
  endsequence
  illegal_trap_a: assert property ( // R20
    start && dvalid && processor_state_word[PSW_PROT_BIT] |=> trap_seq)
    else $error("protect mode did not trap cleanly");
  timeout_v_a: assert property ( // R21
    state inside {ST_DEV_REQ, ST_DEV_REL} && wd_exp
    |=> state == ST_DONE && cc_r == CC_TIMEOUT)
    else $error("time-out did not end with V set");
  wait_bound_a: assert property ( // R22
    $rose(dev_o.req) |-> ##[1:WAIT_BOUND] !dev_o.req)
    else $error("device wait not bounded");
  store_ascend_a: assert property ( // R8
    state == ST_STORE && mem_ack && !mem_fault && !at_end
    |=> ptr == $past(ptr) + 16'h0001)
    else $error("buffer pointer did not step up");
  block_cc_a: assert property ( // R11
    state == ST_STORE && mem_ack && !mem_fault && at_end && op == K_BLKR
    |=> state == ST_DONE && cc_r == CC_NONE ##1 processor_state_word[CC_W-1:0] == CC_NONE)
    else $error("normal block end left cc set");
  leader_skip_a: assert property ( // R16
    state == ST_DEV_REL && !ack_s && !wd_exp && op == K_LOAD && !cmdph &&
    leader && byte_r == 8'h00 |=> state == ST_DEV_REQ && !mem_o.req)
    else $error("leader zero byte was stored");
  pair_order_a: assert property ( // R13
    dev_o.req && op == K_WRH && !memf && !idx |-> dev_o.data == opnd[15:8])
    else $error("pair write sent low byte first");
  idle_start_a: assert property ( // R10
    start |-> state == ST_IDLE && !cpu_hold)
    else $error("new instruction during transfer");
  byte_clear_a: assert property ( // R3
    state == ST_DEV_REL && !ack_s && !wd_exp && op == K_RD && !memf
    |=> res[15:8] == 8'h00 ##1 opnd[7:0] == $past(byte_r, 2))
    else $error("byte read did not clear high byte");
endmodule // io_instruction_sequencer

/* tb/io_dev_model.sv */
// Far-side device model for the sequencer's four-phase byte link.
// Assumes the bench fills feed with read bytes and drains got.
`timescale 1ns/1ps
module io_dev_model
  import io_seq_pkg::*;
(
  input  wire logic            sys_clk,  // System clock.
  input  wire logic            rst,      // Reset, active high.
  input  io_seq_pkg::dev_out_t dev_o,    // Request from sequencer.
  input  wire logic            silent,   // Never answer.
  input  wire logic [3:0]      lag,      // Answer delay in cycles.
  output logic                 dev_ack,  // Acknowledge.
  output logic      [7:0]      dev_rdata // Read byte.
);
  logic [7:0]  feed[$];
  logic [25:0] got[$];
  logic [3:0]  wait_cnt;
  // Released data is inverted so that a stale byte can never pass.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dev_ack   <= 1'b0;
      dev_rdata <= 8'h00;
      wait_cnt  <= 4'h0;
    end else if (dev_o.req && !dev_ack && !silent) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= lag) begin
        wait_cnt <= 4'h0;
        dev_ack  <= 1'b1;
        // Every command is carried out, so examine status never rises.
        got.push_back({dev_o.kind, dev_o.addr, dev_o.data});
        if (dev_o.kind == DK_RD) dev_rdata <= feed.pop_front();
      end
    end else if (!dev_o.req && dev_ack) begin
      dev_ack   <= 1'b0;
      dev_rdata <= ~dev_rdata;
    end
  end
endmodule // io_dev_model

/* tb/io_instruction_sequencer_test.sv */
// Self-checking bench for the I/O sequencer: APB master, memory, device.
// Assumes the design answers APB without waits and drives a byte memory.
`timescale 1ns/1ps
module io_instruction_sequencer_test;
  import io_seq_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, mem_rdata = 8'h00, mem [0:511];
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, err, dev_ack, illegal_irq, cpu_hold, held;
  logic mem_ack = 0, mem_fault = 0, silent = 0;
  logic [3:0] lag = 4'h0;
  logic [7:0] dev_rdata;
  dev_out_t dev_o;
  mem_out_t mem_o;
  int bad_count = 0, check_count = 0, irq_n = 0, cyc = 0;

  io_instruction_sequencer #(.TIMEOUT_CYC(20)) u_io_instruction_sequencer (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dev_o(dev_o), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata), .mem_o(mem_o), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_fault(mem_fault), .illegal_irq(illegal_irq),
    .cpu_hold(cpu_hold));
  io_dev_model u_io_dev_model (.sys_clk(sys_clk), .rst(rst), .dev_o(dev_o),
    .silent(silent), .lag(lag), .dev_ack(dev_ack), .dev_rdata(dev_rdata));

  always #25 sys_clk = ~sys_clk;
  // Stores from 0x180 upward are refused as protected.
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_fault <= 1'b0;
    if (illegal_irq === 1'b1) irq_n++;
    if (mem_o.req === 1'b1 && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_o.addr[8:0]];
      if (mem_o.we && mem_o.addr >= 16'h0180) mem_fault <= 1'b1;
      else if (mem_o.we) mem[mem_o.addr[8:0]] <= mem_o.wdata;
    end
  end
  // The whole run needs a few thousand cycles at most.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask
  task automatic run(input logic [7:0] op);
    wr(OFS_CTRL, {8'h00, op});
    repeat (3) @(posedge sys_clk);
    held = cpu_hold;
    while (cpu_hold === 1'b1) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic dv(input dev_kind_t k, input logic [15:0] a, input logic [7:0] d);
    logic [25:0] g;
    g = u_io_dev_model.got.pop_front();
    if (k == DK_RD) g[7:0] = d;
    chk("device", {6'h00, k, a, d}, {6'h00, g});
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk("psw", OFS_PSW, 32'h0000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    wr(OFS_DEV, 16'h0031);
    wr(OFS_OPND, 16'h00A5);
    run(OPC_CMD);
    dv(DK_CMD, 16'h0031, 8'hA5);
    rdchk("opnd", OFS_OPND, 32'h0000_00A5);
    u_io_dev_model.feed.push_back(8'h5C);
    run(OPC_RD);
    dv(DK_RD, 16'h0031, 8'h00);
    rdchk("byte in", OFS_OPND, 32'h0000_005C);
    wr(OFS_OPND, 16'h12C7);
    run(OPC_WR);
    dv(DK_WR, 16'h0031, 8'hC7);
    run(OPC_WRH);
    dv(DK_WR, 16'h0031, 8'h12);
    dv(DK_WR, 16'h0031, 8'hC7);
    u_io_dev_model.feed = '{8'hAB, 8'hCD};
    run(OPC_RDH);
    rdchk("pair in", OFS_OPND, 32'h0000_ABCD);
    silent <= 1'b1;
    run(OPC_WR);
    rdchk("cc timeout", OFS_PSW, {28'h0, CC_TIMEOUT});
    silent <= 1'b0;
    lag <= 4'h3;
    mem[259] = 8'hEE;
    u_io_dev_model.feed = '{8'h11, 8'h00, 8'h33};
    wr(OFS_OPND, 16'h0100);
    wr(OFS_OPND_NEXT, 16'h0102);
    run(OPC_BLKR);
    chk("hold", 32'h1, {31'h0, held});
    chk("blk", 32'h1100_33EE, {mem[256], mem[257], mem[258], mem[259]});
    rdchk("cc", OFS_PSW, 32'h0000_0000);
    lag <= 4'h0;
    {mem[64], mem[65], mem[66], mem[67]} = 32'h0110_0111;
    {mem[272], mem[273]} = 16'hA1A2;
    u_io_dev_model.got.delete();
    wr(OFS_OPND, 16'h0040);
    run(OPC_BLKW | 8'h40);
    dv(DK_WR, 16'h0031, 8'hA1);
    dv(DK_WR, 16'h0031, 8'hA2);
    run(OPC_WRH | 8'h40);
    dv(DK_WR, 16'h0031, 8'h01);
    dv(DK_WR, 16'h0031, 8'h10);
    u_io_dev_model.feed = '{8'h5A};
    wr(OFS_OPND, 16'h0150);
    run(OPC_RD | 8'h40);
    dv(DK_RD, 16'h0031, 8'h00);
    chk("byte mem", 32'h5A, {24'h0, mem[336]});
    wr(OFS_DEV, 16'h0000);
    {mem[120], mem[121], mem[131]} = 24'h220C_EE;
    u_io_dev_model.feed = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h09};
    wr(OFS_OPND, 16'h0082);
    run(OPC_LOAD | 8'h40);
    dv(DK_CMD, 16'h0022, 8'h0C);
    chk("load", 32'h0700_09EE, {mem[128], mem[129], mem[130], mem[131]});
    u_io_dev_model.feed = '{8'h01, 8'h02, 8'h03};
    wr(OFS_OPND, 16'h017F);
    wr(OFS_OPND_NEXT, 16'h0181);
    run(OPC_BLKR);
    rdchk("cc fault", OFS_PSW, {28'h0, CC_PROTECT});
    u_io_dev_model.got.delete();
    wr(OFS_PSW, 16'h0100);
    run(OPC_WR);
    chk("trap", 32'h1, irq_n);
    chk("no xfer", 32'h0, u_io_dev_model.got.size());
    rdchk("sticky", OFS_STATUS, 32'h0000_0002);
    run(OPC_LOAD);
    rdchk("bad op", OFS_STATUS, 32'h0000_0006);
    wr(OFS_STATUS, 16'h0006);
    rdchk("cleared", OFS_STATUS, 32'h0000_0000);
    final_report();
  end
endmodule // io_instruction_sequencer_test
